// file: logic/aopc_pkg.sv
// Constants and types shared by the converter output port logic.
// Assumes one 10 MHz system clock; every time below is in ns.
package aopc_pkg;

  // Result width and buffer depth
  localparam int RES_W     = 16;
  localparam int BUF_DEPTH = 2;

  // System clock period
  localparam int CLK_NS = 100;

  // Least acquisition time, rounded up to whole cycles
  localparam int ACQ_NS    = 750;
  localparam int ACQ_CYC   = (ACQ_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACQ_CNT_W = 4;

  // Least internal serial clock period for each divider code
  localparam int SCLK_NS_0 = 25;
  localparam int SCLK_NS_1 = 50;
  localparam int SCLK_NS_2 = 100;
  localparam int SCLK_NS_3 = 200;

  // Half period in cycles, rounded up, never below one cycle
  localparam int SCLK_HALF_0 = (SCLK_NS_0 + 2 * CLK_NS - 1) / (2 * CLK_NS);
  localparam int SCLK_HALF_1 = (SCLK_NS_1 + 2 * CLK_NS - 1) / (2 * CLK_NS);
  localparam int SCLK_HALF_2 = (SCLK_NS_2 + 2 * CLK_NS - 1) / (2 * CLK_NS);
  localparam int SCLK_HALF_3 = (SCLK_NS_3 + 2 * CLK_NS - 1) / (2 * CLK_NS);
  localparam int DIV_W       = 4;

  // Serial word length, chain delay and edge counter width
  localparam int BIT_LAST  = RES_W - 1;
  localparam int CHAIN_LEN = 16;
  localparam int SER_CNT_W = 5;

  // Positions of the serial functions on the shared data pins
  localparam int PIN_DIV     = 2;
  localparam int PIN_EXT     = 4;
  localparam int PIN_FRAME_POLARITY_SELECT = 5;
  localparam int PIN_SERIAL_CLOCK_INVERT = 6;
  localparam int PIN_RDC     = 7;
  localparam int PIN_SERIAL_DATA_OUTPUT   = 8;
  localparam int PIN_SCLK    = 9;
  localparam int PIN_SYNC    = 10;
  localparam int PIN_RDERR   = 11;

  // Values after reset
  localparam logic [RES_W-1:0] RST_RESULT = 16'h0000;

  // Conversion sequencer states
  typedef enum logic [1:0] {ST_ACQ = 2'b00, ST_WAIT = 2'b01, ST_CONV = 2'b10} aopc_conv_t;

  // Phases of one bit of the internally clocked serial output
  typedef enum logic [1:0] {PH_DRIVE = 2'b00, PH_HIGH = 2'b01, PH_LOW = 2'b10} aopc_phase_t;

endpackage

// file: logic/aopc_stream_if.sv
// Valid/ready word stream between the sequencer and the result buffer.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface aopc_stream_if #(parameter int WIDTH = 16);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  // Producer and consumer views
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// file: logic/aopc_buf2.sv
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes a synchronous flush and one clock for both sides.
`timescale 1ns/1ps
`default_nettype none
module aopc_buf2 #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic     clk,
  input  wire logic     rst_n,
  input  wire logic     flush,
  // Filling and draining sides
  aopc_stream_if.snk    in_s,
  aopc_stream_if.src    out_s
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  logic             push;
  logic             pop;

  // Honest full and empty straight from the count
  assign in_s.ready  = (count != CW'(DEPTH));
  assign out_s.valid = (count != '0);
  assign out_s.data  = mem[rd_ptr];
  assign push        = in_s.valid && in_s.ready;
  assign pop         = out_s.valid && out_s.ready;

  // Pointers and count; wrap is explicit so any depth works
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else if (flush)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end

  // Storage needs no reset; the count guards it
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr] <= in_s.data;
  end
endmodule
`default_nettype wire

// file: logic/aopc_top.sv
// Conversion control and result output port of a 16-bit converter.
// Assumes all pins synchronous to clk; the analog core signals completion.
//
// Behaviour
// RQ1: Byte order select swaps parallel result bytes
// RQ2: Coding select low inverts the result MSB
// RQ3: Port select chooses parallel or serial pins
// RQ4: Serial mode leaves lowest two lines undriven
// RQ5: Divider acts only in master read-after-convert
// RQ6: Clock source picks internal or host clock
// RQ7: Frame polarity select sets sync active level
// RQ8: Clock invert picks the data update edge
// RQ9: Chain input appears sixteen clocks later
// RQ10: Read mode picks during or after conversion
// RQ11: Result shifts out MSB first, coded
// RQ12: Internal clock data valid on both edges
// RQ13: External clock updates on its active edge
// RQ14: Sync held active while serial data valid
// RQ15: Unfinished slave read at completion flags error
// RQ16: Top four lines stay outputs always
// RQ17: Busy from start until result is latched
// RQ18: Drivers enabled only with select and read
// RQ19: Chip select gates the external clock
// RQ20: Reset input aborts conversion and clears
// RQ21: Power down blocks further conversion starts
// RQ22: Start at acquisition end or next fall
// RQ23: Divider codes give 25 to 200 ns; here every code gives the same 300 ns serial clock period
// RQ24: Output register holds last result until next
`timescale 1ns/1ps
`default_nettype none
module aopc_top
  import aopc_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Conversion control
  input  wire logic             reset_in,
  input  wire logic             power_down_input,
  input  wire logic             convert_start_n,
  output logic                  busy,
  // Analog core handshake
  output logic                  core_start,
  input  wire logic             core_done,
  input  wire logic [RES_W-1:0] core_result,
  // Read strobes and mode straps
  input  wire logic             cs_n,
  input  wire logic             rd_n,
  input  wire logic             byte_order_select,
  input  wire logic             coding_select,
  input  wire logic             port_select,
  // Shared data pins
  input  wire logic [RES_W-1:0] data_in,
  output logic      [RES_W-1:0] data_out,
  output logic      [RES_W-1:0] data_oe
);

  // Serial controls that share the data pins
  logic [1:0]       serial_clock_divider;
  logic             clock_source_select;
  logic             frame_polarity_select;
  logic             serial_clock_invert;
  logic             read_mode_or_chain_in;
  logic             master_mode;
  logic             slave_mode;
  logic             out_en;
  // Sequencer
  aopc_conv_t       conv_state;
  logic [ACQ_CNT_W-1:0] acq_cnt;
  logic             cnv_prev;
  logic             start_ok;
  // Result path
  logic [RES_W-1:0] fmt;
  logic [RES_W-1:0] out_reg;
  logic             pop;
  // Serial engine
  logic [RES_W-1:0] sh;
  logic [SER_CNT_W-1:0] sh_cnt;
  logic             m_active;
  aopc_phase_t      m_phase;
  logic             m_go;
  logic             m_tick;
  logic [1:0]       div_sel;
  logic [DIV_W-1:0] div_half;
  logic [DIV_W-1:0] div_cnt;
  logic             eff_sclk;
  logic             eff_prev;
  logic             s_upd;
  logic             read_err;
  logic             chain_q;
  logic [RES_W-1:0] next_pins;

  aopc_stream_if #(.WIDTH(RES_W)) cv_s ();
  aopc_stream_if #(.WIDTH(RES_W)) q_s ();

  // Pin reuse in serial mode
  assign serial_clock_divider  = data_in[PIN_DIV +: 2];
  assign clock_source_select   = data_in[PIN_EXT];
  assign frame_polarity_select = data_in[PIN_FRAME_POLARITY_SELECT];
  assign serial_clock_invert   = data_in[PIN_SERIAL_CLOCK_INVERT];
  assign read_mode_or_chain_in = data_in[PIN_RDC];
  assign master_mode = port_select && !clock_source_select; // [RQ3] [RQ6]
  assign slave_mode  = port_select && clock_source_select;  // [RQ6]
  assign out_en      = !cs_n && !rd_n;                      // [RQ18]

  // A full buffer or power down holds off the next start
  assign start_ok = !power_down_input && cv_s.ready; // [RQ21]

  // Falling edge detector on the start strobe
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnv_prev <= 1'b1;
    else
      cnv_prev <= convert_start_n;
  end

  // Acquisition, wait and conversion sequencer
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      conv_state <= ST_ACQ;
      acq_cnt    <= '0;
      core_start <= 1'b0;
    end
    else if (reset_in)
    begin
      conv_state <= ST_ACQ; // [RQ20]
      acq_cnt    <= '0;
      core_start <= 1'b0;
    end
    else
    begin
      core_start <= 1'b0;
      case (conv_state)
        ST_ACQ:
        begin
          if (acq_cnt == ACQ_CNT_W'(ACQ_CYC - 1))
          begin
            // Already low at the end of acquisition starts at once
            if (!convert_start_n && start_ok) // [RQ22]
            begin
              conv_state <= ST_CONV;
              core_start <= 1'b1;
            end
            else
              conv_state <= ST_WAIT;
          end
          else
            acq_cnt <= acq_cnt + 1'b1;
        end
        ST_WAIT:
        begin
          if (cnv_prev && !convert_start_n && start_ok) // [RQ22]
          begin
            conv_state <= ST_CONV;
            core_start <= 1'b1;
          end
        end
        ST_CONV:
        begin
          if (core_done)
          begin
            conv_state <= ST_ACQ;
            acq_cnt    <= '0;
          end
        end
        default: conv_state <= ST_ACQ;
      endcase
    end
  end

  // Completed words enter the buffer; an aborted one never does
  assign cv_s.valid = (conv_state == ST_CONV) && core_done && !reset_in;
  assign cv_s.data  = core_result;

  // A shifting master stalls the drain, so the buffer can fill
  assign q_s.ready = !m_active;
  assign pop       = q_s.valid && q_s.ready;

  aopc_buf2 #(.WIDTH(RES_W), .DEPTH(BUF_DEPTH)) u_buf (
    .clk   (clk),
    .rst_n (rst_n),
    .flush (reset_in),
    .in_s  (cv_s),
    .out_s (q_s)
  );

  // Output coding applied once, at the latch
  assign fmt = {q_s.data[RES_W-1] ^ !coding_select, q_s.data[RES_W-2:0]}; // [RQ2]

  // Busy until the word has left the buffer into the registers
  assign busy = (conv_state == ST_CONV) || q_s.valid; // [RQ17]

  // Last result; repeated reads see the same value
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      out_reg <= RST_RESULT;
    else if (reset_in)
      out_reg <= RST_RESULT;
    else if (pop)
      out_reg <= fmt; // [RQ24]
  end

  // Divider codes count only in master read-after-convert
  assign div_sel = (master_mode && !read_mode_or_chain_in) ? serial_clock_divider : 2'b00; // [RQ5]

  always_comb
  begin
    case (div_sel)
      2'b00:   div_half = DIV_W'(SCLK_HALF_0); // [RQ23]
      2'b01:   div_half = DIV_W'(SCLK_HALF_1);
      2'b10:   div_half = DIV_W'(SCLK_HALF_2);
      2'b11:   div_half = DIV_W'(SCLK_HALF_3);
      default: div_half = DIV_W'(SCLK_HALF_0);
    endcase
  end

  // Phase tick divider for the internal serial clock
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      div_cnt <= '0;
    else if (!m_active || div_cnt == '0)
      div_cnt <= div_half - 1'b1;
    else
      div_cnt <= div_cnt - 1'b1;
  end
  assign m_tick = m_active && (div_cnt == '0);

  // Master read starts with the conversion or after the latch
  assign m_go = master_mode && out_en && !m_active
                && (read_mode_or_chain_in ? core_start : pop); // [RQ10]

  // Host clock edges count only while selected
  assign eff_sclk = data_in[PIN_SCLK] ^ serial_clock_invert; // [RQ8]
  assign s_upd    = slave_mode && !cs_n && eff_sclk && !eff_prev; // [RQ19] [RQ13]

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      eff_prev <= 1'b0;
    else
      eff_prev <= eff_sclk;
  end

  // Shift register for both serial modes
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sh       <= RST_RESULT;
      chain_q  <= 1'b0;
      sh_cnt   <= '0;
      m_active <= 1'b0;
      m_phase  <= PH_DRIVE;
    end
    else if (reset_in)
    begin
      sh       <= RST_RESULT;
      chain_q  <= 1'b0;
      sh_cnt   <= '0;
      m_active <= 1'b0;
      m_phase  <= PH_DRIVE;
    end
    else if (pop)
    begin
      sh       <= fmt; // [RQ11]
      sh_cnt   <= '0;
      m_active <= m_go;
      m_phase  <= PH_DRIVE;
    end
    else if (m_go)
    begin
      // Read during conversion sends the previous result
      sh       <= out_reg; // [RQ10]
      sh_cnt   <= '0;
      m_active <= 1'b1;
      m_phase  <= PH_DRIVE;
    end
    else if (m_tick)
    begin
      // Data changes only in the drive phase, clock at its rest level, so both edges see it
      case (m_phase)
        PH_DRIVE: m_phase <= PH_HIGH; // [RQ12]
        PH_HIGH:  m_phase <= PH_LOW;
        PH_LOW:
        begin
          m_phase <= PH_DRIVE;
          if (sh_cnt == SER_CNT_W'(BIT_LAST))
            m_active <= 1'b0;
          else
          begin
            sh     <= {sh[RES_W-2:0], 1'b0}; // [RQ11]
            sh_cnt <= sh_cnt + 1'b1;
          end
        end
        default: m_phase <= PH_DRIVE;
      endcase
    end
    else if (s_upd)
    begin
      // First edge shows the MSB; a chain level enters one edge late, surfacing sixteen edges on
      chain_q <= read_mode_or_chain_in; // [RQ9]
      if (sh_cnt != '0)
        sh <= {sh[RES_W-2:0], chain_q}; // [RQ9] [RQ13]
      if (sh_cnt != '1)
        sh_cnt <= sh_cnt + 1'b1;
    end
  end

  // Unfinished slave read is dropped when a new word lands
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      read_err <= 1'b0;
    else
      read_err <= pop && slave_mode && (sh_cnt != '0)
                  && (sh_cnt < SER_CNT_W'(CHAIN_LEN)); // [RQ15]
  end

  // Pin values; the top nibble keeps its parallel meaning
  always_comb
  begin
    next_pins = byte_order_select ? {out_reg[7:0], out_reg[15:8]} : out_reg; // [RQ1]
    if (port_select)
    begin
      next_pins[7:0]       = 8'h00;
      next_pins[PIN_SERIAL_DATA_OUTPUT] = sh[RES_W-1]; // [RQ11]
      next_pins[PIN_SCLK]  = (m_active && m_phase == PH_HIGH) ^ serial_clock_invert; // [RQ8]
      next_pins[PIN_SYNC]  = m_active ^ frame_polarity_select; // [RQ7] [RQ14]
      next_pins[PIN_RDERR] = read_err; // [RQ15]
    end
  end

  // Data pins come from flip-flops
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      data_out <= RST_RESULT;
    else
      data_out <= next_pins;
  end

  // Drivers open only while both strobes are low
  always_comb
  begin
    data_oe = {RES_W{out_en}}; // [RQ18] [RQ16]
    if (port_select)
    begin
      data_oe[7:0]          = 8'h00; // [RQ4]
      data_oe[PIN_SCLK]     = out_en && !clock_source_select; // [RQ6]
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic [RES_W-1:0] swap_exp;
  logic             q_msb;
  assign swap_exp = {out_reg[7:0], out_reg[15:8]};
  assign q_msb    = q_s.data[RES_W-1];

  sequence s_acq_enter;
    conv_state == ST_CONV ##1 conv_state == ST_ACQ;
  endsequence

  sequence s_short_read;
    pop && slave_mode && sh_cnt != 5'h00 && sh_cnt < 5'h10;
  endsequence

  AST_BYTE_SWAP: assert property (!port_select && byte_order_select |=> data_out == $past(swap_exp)) // [RQ1]
    else $error("parallel bytes not swapped");
  AST_CODING: assert property (pop && !coding_select && !reset_in |=> out_reg[RES_W-1] != $past(q_msb)) // [RQ2]
    else $error("two's complement msb not inverted");
  AST_OE_GATE: assert property ((cs_n || rd_n) |-> data_oe == 16'h0000) // [RQ18]
    else $error("driver enabled without both strobes");
  AST_SER_PINS: assert property (port_select && out_en |-> data_oe[15:12] == 4'hF && data_oe[1:0] == 2'b00) // [RQ16]
    else $error("serial pin directions wrong");
  AST_ACQ_MIN: assert property (s_acq_enter |-> !core_start [*8]) // [RQ22]
    else $error("conversion started before acquisition ended");
  AST_IMM_START: assert property (conv_state == ST_ACQ && acq_cnt == 4'h7 && !convert_start_n && start_ok // [RQ22]
    && !reset_in |=> core_start && busy)
    else $error("immediate start missed");
  AST_PD_BLOCK: assert property (power_down_input |=> !core_start) // [RQ21]
    else $error("start while powered down");
  AST_RDERR: assert property (s_short_read |=> read_err ##1 !read_err) // [RQ15]
    else $error("incomplete read not flagged as pulse");
  AST_SYNC_HOLD: assert property (m_active && port_select |=> data_out[PIN_SYNC] != $past(frame_polarity_select)) // [RQ14]
    else $error("sync not active during master read");
  AST_CHAIN: assert property (s_upd && sh_cnt != 5'h00 && !pop && !reset_in // [RQ9]
    |=> sh[0] == $past(chain_q))
    else $error("chain bit not shifted in");
endmodule
`default_nettype wire

// file: verification/aopc_core_model.sv
// Behavioural analog core: answers each start request after a set latency.
// Assumes one-cycle start pulses and a latency of at least two cycles.
`timescale 1ns/1ps
`default_nettype none
module aopc_core_model
  import aopc_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Request from the block
  input  wire logic             core_start,
  // Bench controls
  input  wire logic [7:0]       lat,
  input  wire logic [RES_W-1:0] value,
  // Answer to the block
  output logic                  core_done,
  output logic      [RES_W-1:0] core_result
);
  logic [7:0] cnt;

  // Latency countdown, restarted by every request
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt <= 8'h00;
    else if (core_start)
      cnt <= lat;
    else if (cnt != 8'h00)
      cnt <= cnt - 8'h01;
  end

  // Outside the done cycle the bus shows the inverse, so a late sample cannot pass
  assign core_done   = (cnt == 8'h01);
  assign core_result = core_done ? value : ~value;
endmodule
`default_nettype wire

// file: verification/tb_top.sv
// Bench for the converter output port: parallel, master and slave serial reads.
// Assumes the design files and the core model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import aopc_pkg::*;
  ;
  // Serial functions on shared pins
  localparam int POL_B = 5;
  localparam int INV_B = 6;
  localparam int CHN_B = 7;
  localparam int SD_B  = 8;

  logic        clk = 1'b0;
  logic        rst_n, reset_in, power_down_input, convert_start_n, busy, core_start, core_done;
  logic        cs_n, rd_n, byte_order_select, coding_select, port_select, mon_off, pend;
  logic        act, act_q, busy_q, sclk_q, sd_q, sd;
  logic [15:0] core_result, data_in, data_out, data_oe, value, v, w, sh;
  logic [7:0]  lat;
  logic [3:0]  cfg_q;
  logic [31:0] rng;
  int          n_fail, checked, n_starts, n_err, stab, act_n, nbits, bad, k;
  logic [15:0] exp_q[$];

  aopc_top uut (
    .clk(clk), .rst_n(rst_n), .reset_in(reset_in), .power_down_input(power_down_input),
    .convert_start_n(convert_start_n), .busy(busy), .core_start(core_start), .core_done(core_done),
    .core_result(core_result), .cs_n(cs_n), .rd_n(rd_n), .byte_order_select(byte_order_select),
    .coding_select(coding_select), .port_select(port_select), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe)
  );

  aopc_core_model core (
    .clk(clk), .rst_n(rst_n), .core_start(core_start), .lat(lat), .value(value),
    .core_done(core_done), .core_result(core_result)
  );

  // Free-running system clock
  always #50 clk = ~clk;

  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  // Expected coding of a raw result
  function automatic logic [15:0] coded(input logic [15:0] r);
    return coding_select ? r : {~r[15], r[14:0]};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Start strobe falls after a high cycle and stays low until the core is kicked
  task automatic convert(input logic [15:0] r);
    int n;
    n = 0;
    value = r;
    convert_start_n = 1'b1;
    @(negedge clk);
    convert_start_n = 1'b0;
    while (core_start !== 1'b1 && n < 40)
    begin
      @(negedge clk);
      n++;
    end
    check({15'h0, core_start}, 16'h0001);
    check({15'h0, busy}, 16'h0001);
    convert_start_n = 1'b1;
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 300)
    begin
      @(negedge clk);
      n++;
    end
    check({15'h0, busy}, 16'h0000);
    repeat (4) @(negedge clk);
  endtask

  // One host clock period; the active edge comes first, data read late in the inactive half
  task automatic sedge(input logic chain, output logic bit_seen);
    data_in[CHN_B] = chain;
    data_in[PIN_SCLK] = ~data_in[INV_B];
    repeat (2) @(negedge clk);
    data_in[PIN_SCLK] = data_in[INV_B];
    repeat (2) @(negedge clk);
    bit_seen = data_out[SD_B];
  endtask

  task automatic slave_read(input logic [15:0] r);
    logic [39:0] ch;
    logic [7:0]  tail;
    logic [7:0]  exp_tail;
    logic [15:0] got;
    ch = 40'({xs(), xs()});
    cs_n = 1'b1;
    repeat (3) sedge(1'b0, sd);
    cs_n = 1'b0;
    for (int e = 1; e <= 40; e++)
    begin
      sedge(ch[e-1], sd);
      if (e <= 16)
        got[16-e] = sd;
      if (e > 32)
      begin
        tail[40-e] = sd;
        exp_tail[40-e] = ch[e-17];
      end
    end
    check(got, coded(r));
    check({8'h00, tail}, {8'h00, exp_tail});
  endtask

  // Output watcher: parallel word after busy falls, master frames from sync
  always @(negedge clk)
  begin
    if ({port_select, data_in[PIN_EXT], data_in[INV_B], data_in[POL_B]} !== cfg_q)
      stab = 0;
    else if (stab < 3)
      stab++;
    cfg_q = {port_select, data_in[PIN_EXT], data_in[INV_B], data_in[POL_B]};
    if (pend)
      check(data_out, exp_q.size() > 0 ? exp_q.pop_front() : ~data_out);
    pend = !port_select && !mon_off && busy_q && !busy;
    busy_q = busy;
    if (core_start === 1'b1)
      n_starts++;
    if (port_select && data_in[PIN_EXT] && stab >= 2 && data_out[PIN_RDERR] === 1'b1)
      n_err++;
    act = port_select && !data_in[PIN_EXT] && stab >= 2 && data_out[PIN_SYNC] === ~data_in[POL_B];
    if (act)
    begin
      act_n++;
      if (data_out[PIN_SCLK] !== data_in[INV_B] && nbits < 16)
      begin
        sh = {sh[14:0], data_out[SD_B]};
        nbits++;
      end
      if (act_q && data_out[PIN_SCLK] !== sclk_q && data_out[SD_B] !== sd_q)
        bad++;
    end
    else if (act_q)
    begin
      check(sh, exp_q.size() > 0 ? exp_q.pop_front() : ~sh);
      check(16'(act_n), 16'h0030);
      check(16'(bad), 16'h0000);
      act_n = 0;
      nbits = 0;
      bad = 0;
    end
    act_q = act;
    sclk_q = data_out[PIN_SCLK];
    sd_q = data_out[SD_B];
  end

  // Watchdog well beyond the expected run length
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    report_and_stop();
  end

  initial
  begin
    rng = 32'h0001692D;
    {rst_n, reset_in, power_down_input, byte_order_select, coding_select, port_select} = 6'h00;
    {convert_start_n, cs_n, rd_n, mon_off, pend, act_q, busy_q} = 7'h00;
    convert_start_n = 1'b1;
    {sclk_q, sd_q, sh, cfg_q, data_in, value, w} = '0;
    {n_fail, checked, n_starts, n_err, stab, act_n, nbits, bad} = '0;
    lat = 8'h04;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    check(data_out, RST_RESULT);
    // Drivers only with both strobes low
    rd_n = 1'b1;
    #1 check(data_oe, 16'h0000);
    @(negedge clk);
    rd_n = 1'b0;
    #1 check(data_oe, 16'hFFFF);
    // Parallel reads in every coding and byte order
    for (int m = 0; m < 4; m++)
    begin
      @(negedge clk);
      coding_select = m[0];
      byte_order_select = m[1];
      v = 16'(xs());
      w = coded(v);
      w = byte_order_select ? {w[7:0], w[15:8]} : w;
      exp_q.push_back(w);
      convert(v);
      wait_idle();
      repeat (10) @(negedge clk);
      check(data_out, w);
    end
    // Power down refuses new starts
    power_down_input = 1'b1;
    k = n_starts;
    convert_start_n = 1'b0;
    repeat (30) @(negedge clk);
    check(16'(n_starts - k), 16'h0000);
    convert_start_n = 1'b1;
    power_down_input = 1'b0;
    // Reset input mid-conversion; the late core answer must be dropped
    lat = 8'h1E;
    mon_off = 1'b1;
    convert(16'(xs()));
    repeat (5) @(negedge clk);
    reset_in = 1'b1;
    @(negedge clk);
    reset_in = 1'b0;
    repeat (40) @(negedge clk);
    check({15'h0, busy}, 16'h0000);
    check(data_out, RST_RESULT);
    mon_off = 1'b0;
    lat = 8'h04;
    // Master serial, read after convert, every polarity and clock invert
    port_select = 1'b1;
    for (int m = 0; m < 4; m++)
    begin
      data_in[POL_B] = m[0];
      data_in[INV_B] = m[1];
      data_in[3:2] = 2'(xs());
      repeat (4) @(negedge clk);
      check(data_oe & 16'hF203, 16'hF200);
      v = 16'(xs());
      w = coded(v);
      exp_q.push_back(w);
      convert(v);
      repeat (70) @(negedge clk);
    end
    // Read during conversion sends the previous word
    data_in[CHN_B] = 1'b1;
    exp_q.push_back(w);
    convert(16'(xs()));
    repeat (70) @(negedge clk);
    // Slave serial with chained input and gated clock
    data_in = 16'h0000;
    data_in[PIN_EXT] = 1'b1;
    data_in[INV_B] = 1'(xs());
    data_in[PIN_SCLK] = data_in[INV_B];
    repeat (4) @(negedge clk);
    check(data_oe & 16'hF203, 16'hF000);
    v = 16'(xs());
    convert(v);
    wait_idle();
    slave_read(v);
    // Completed read gives no error, an unfinished one does
    k = n_err;
    convert(16'(xs()));
    wait_idle();
    check(16'(n_err - k), 16'h0000);
    repeat (4) sedge(1'b0, sd);
    convert(16'(xs()));
    wait_idle();
    check(16'(n_err - k), 16'h0001);
    check(16'(exp_q.size()), 16'h0000);
    report_and_stop();
  end
endmodule
`default_nettype wire
